// >>> inc/dso_pkg.sv
// shared constants for the drive status output selector
package dso_pkg;

    // default widths
    localparam int DSO_FREQ_W = 16;
    localparam int DSO_VOLT_W = 12;
    localparam int DSO_SEL_W = 5;

    // output channels
    localparam int DSO_NUM_CH = 3;
    localparam int DSO_CH_RELAY_ONE = 0;
    localparam int DSO_CH_RELAY_TWO = 1;
    localparam int DSO_CH_OPEN_COLL = 2;

    // selection codes
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_NONE = 5'h00;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_REF_REACH = 5'h01;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_TARGET_REACH = 5'h02;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_OP_MATCH = 5'h03;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_ACC_DEC = 5'h04;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_MOTOR_OVL = 5'h05;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_INV_OVL = 5'h06;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_UNDERLOAD = 5'h07;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_FAN_WARN = 5'h08;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_STALL = 5'h09;
    localparam logic [DSO_SEL_W-1:0] DSO_SEL_OVER_VOLT = 5'h0A;

    // reset values
    localparam logic DSO_OUT_RESET = 1'h0;
    localparam logic [DSO_NUM_CH-1:0] DSO_OUT_RESET_VEC = 3'h0;

    // band is compared at half width
    localparam int DSO_HALF_SHIFT = 1;

endpackage : dso_pkg

// >>> src/dso_cond_eval.sv
// one output channel: selection decode and condition evaluation
`timescale 1ns/1ps
module dso_cond_eval #(
    parameter int FREQ_W = dso_pkg::DSO_FREQ_W,
    parameter int SEL_W = dso_pkg::DSO_SEL_W
) (
    // selection
    input wire logic [SEL_W-1:0] sel,
    // frequencies and detection settings
    input wire logic [FREQ_W-1:0] referenceFreq,
    input wire logic [FREQ_W-1:0] outputFreq,
    input wire logic [FREQ_W-1:0] operationFreq,
    input wire logic [FREQ_W-1:0] detectFreq,
    input wire logic [FREQ_W-1:0] detectBand,
    // drive direction
    input wire logic accelerating,
    input wire logic decelerating,
    // fault and warning indications
    input wire logic motorOverload,
    input wire logic inverterOverloadFault,
    input wire logic underloadWarning,
    input wire logic fanWarning,
    input wire logic motorStall,
    input wire logic overVoltage,
    // registered state of this channel
    input wire logic prevOut,
    // condition for the next edge
    output logic cond
);
    import dso_pkg::*;

    function automatic logic [FREQ_W-1:0] absDiff(input logic [FREQ_W-1:0] a,
                                                  input logic [FREQ_W-1:0] b);
        absDiff = (a >= b) ? (a - b) : (b - a);
    endfunction : absDiff

    logic [FREQ_W-1:0] halfBand;
    logic refReach;
    logic targetNear;
    logic opMatch;
    logic accelHit;
    logic decelHit;

    assign halfBand = detectBand >> DSO_HALF_SHIFT;
    assign refReach = absDiff(referenceFreq, outputFreq) < halfBand; // see R2
    assign targetNear = absDiff(outputFreq, detectFreq) < halfBand; // see R3
    assign opMatch = absDiff(outputFreq, operationFreq) < halfBand; // see R4
    assign accelHit = operationFreq >= detectFreq; // see R5
    // op > det - half, rearranged so that no underflow can occur
    assign decelHit = ({1'b0, operationFreq} + {1'b0, halfBand}) > {1'b0, detectFreq}; // see R6

    always_comb begin
        case (sel)
            DSO_SEL_NONE: cond = DSO_OUT_RESET; // see R1
            DSO_SEL_REF_REACH: cond = refReach; // see R2
            DSO_SEL_TARGET_REACH: cond = refReach && targetNear; // see R3
            DSO_SEL_OP_MATCH: cond = opMatch; // see R4
            DSO_SEL_ACC_DEC: begin
                // steady running keeps the last decision
                if (accelerating) begin
                    cond = accelHit; // see R5
                end else if (decelerating) begin
                    cond = decelHit; // see R6
                end else begin
                    cond = prevOut;
                end
            end
            DSO_SEL_MOTOR_OVL: cond = motorOverload; // see R7
            DSO_SEL_INV_OVL: cond = inverterOverloadFault; // see R8
            DSO_SEL_UNDERLOAD: cond = underloadWarning; // see R9
            DSO_SEL_FAN_WARN: cond = fanWarning; // see R10
            DSO_SEL_STALL: cond = motorStall; // see R11
            DSO_SEL_OVER_VOLT: cond = overVoltage; // see R12
            default: cond = DSO_OUT_RESET;
        endcase
    end

endmodule : dso_cond_eval

// >>> src/dso_status_select.sv
// drive status output selector: three selectable status outputs
`timescale 1ns/1ps

// Functional notes
// R1: code 0 keeps output off
// R2: code 1: reference near output frequency
// R3: code 2: code 1 and output near detect
// R4: code 3: output near operation frequency
// R5: code 4 accelerating: operation at least detect
// R6: code 4 decelerating: operation above detect minus half
// R7: code 5 follows motor overload
// R8: code 6 follows inverter overload fault
// R9: code 7 follows underload warning
// R10: code 8 follows fan warning
// R11: code 9 follows motor stall
// R12: code 10 follows over-voltage indication
// R13: over-voltage when link above threshold
// R14: shared settings, separate code per output
// R15: first relay has own selection
// R16: evaluate every clock, registered outputs
module dso_status_select #(
    parameter int FREQ_W = dso_pkg::DSO_FREQ_W,
    parameter int VOLT_W = dso_pkg::DSO_VOLT_W,
    parameter int SEL_W = dso_pkg::DSO_SEL_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // selection codes
    input wire logic [SEL_W-1:0] relayOneSelect,
    input wire logic [SEL_W-1:0] relayTwoSelect,
    input wire logic [SEL_W-1:0] digitalOutputSelect,
    // detection settings
    input wire logic [FREQ_W-1:0] detectionFrequencySetting,
    input wire logic [FREQ_W-1:0] detectionBandSetting,
    // drive frequencies
    input wire logic [FREQ_W-1:0] referenceFreq,
    input wire logic [FREQ_W-1:0] outputFreq,
    input wire logic [FREQ_W-1:0] operationFreq,
    // drive direction
    input wire logic accelerating,
    input wire logic decelerating,
    // fault and warning indications
    input wire logic motorOverload,
    input wire logic inverterOverloadFault,
    input wire logic underloadWarning,
    input wire logic fanWarning,
    input wire logic motorStall,
    // dc link
    input wire logic [VOLT_W-1:0] dcLinkVoltage,
    input wire logic [VOLT_W-1:0] overVoltageLevel,
    // status outputs
    output logic relayOne,
    output logic relayTwo,
    output logic openCollectorOutput,
    output logic overVoltage
);
    import dso_pkg::*;

    function automatic logic [FREQ_W-1:0] absDiff(input logic [FREQ_W-1:0] a,
                                                  input logic [FREQ_W-1:0] b);
        absDiff = (a >= b) ? (a - b) : (b - a);
    endfunction : absDiff

    logic [SEL_W-1:0] selArr [DSO_NUM_CH];
    logic [DSO_NUM_CH-1:0] outState_reg;
    logic [DSO_NUM_CH-1:0] outState_next;
    logic overVoltNow;
    logic overVoltage_reg;

    // each output has its own code; settings are shared
    assign selArr[DSO_CH_RELAY_ONE] = relayOneSelect; // see R15
    assign selArr[DSO_CH_RELAY_TWO] = relayTwoSelect; // see R14
    assign selArr[DSO_CH_OPEN_COLL] = digitalOutputSelect; // see R14

    assign overVoltNow = dcLinkVoltage > overVoltageLevel; // see R13

    for (genvar ch = 0; ch < DSO_NUM_CH; ch++) begin : g_ch
        dso_cond_eval #(
            .FREQ_W(FREQ_W),
            .SEL_W(SEL_W)
        ) u_eval (
            .sel(selArr[ch]),
            .referenceFreq(referenceFreq),
            .outputFreq(outputFreq),
            .operationFreq(operationFreq),
            .detectFreq(detectionFrequencySetting),
            .detectBand(detectionBandSetting),
            .accelerating(accelerating),
            .decelerating(decelerating),
            .motorOverload(motorOverload),
            .inverterOverloadFault(inverterOverloadFault),
            .underloadWarning(underloadWarning),
            .fanWarning(fanWarning),
            .motorStall(motorStall),
            .overVoltage(overVoltNow),
            .prevOut(outState_reg[ch]),
            .cond(outState_next[ch])
        );
    end

    // outputs change only on a clock edge, recomputed every cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            outState_reg <= DSO_OUT_RESET_VEC;
        end else begin
            outState_reg <= outState_next; // see R16
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            overVoltage_reg <= DSO_OUT_RESET;
        end else begin
            overVoltage_reg <= overVoltNow; // see R13
        end
    end

    assign relayOne = outState_reg[DSO_CH_RELAY_ONE];
    assign relayTwo = outState_reg[DSO_CH_RELAY_TWO];
    assign openCollectorOutput = outState_reg[DSO_CH_OPEN_COLL];
    assign overVoltage = overVoltage_reg;

    // helper terms for the checks below
    logic [FREQ_W-1:0] chkHalf;
    logic chkRef;
    logic chkTarget;
    logic chkOp;
    logic chkDecel;
    assign chkHalf = detectionBandSetting >> DSO_HALF_SHIFT;
    assign chkRef = absDiff(referenceFreq, outputFreq) < chkHalf;
    assign chkTarget = absDiff(outputFreq, detectionFrequencySetting) < chkHalf;
    assign chkOp = absDiff(outputFreq, operationFreq) < chkHalf;
    // threshold below zero counts as passed by any operation frequency
    assign chkDecel = (chkHalf > detectionFrequencySetting)
        || (operationFreq > detectionFrequencySetting - chkHalf);

    a_none_off: assert property ( // see R1
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_NONE) [*2] |-> !relayOne
    ) else $error("relay one active with selection none");

    a_ref_reach: assert property ( // see R2
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_REF_REACH) |=> (relayOne == $past(chkRef))
    ) else $error("reference reach output wrong");

    a_target_reach: assert property ( // see R3
        @(posedge clock) disable iff (!rst_n)
        (relayTwoSelect == DSO_SEL_TARGET_REACH)
            |=> (relayTwo == ($past(chkRef) && $past(chkTarget)))
    ) else $error("target reach output wrong");

    a_op_match: assert property ( // see R4
        @(posedge clock) disable iff (!rst_n)
        (digitalOutputSelect == DSO_SEL_OP_MATCH)
            |=> (openCollectorOutput == $past(chkOp))
    ) else $error("operation match output wrong");

    a_accel_thresh: assert property ( // see R5
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_ACC_DEC && accelerating)
            |=> (relayOne == ($past(operationFreq) >= $past(detectionFrequencySetting)))
    ) else $error("acceleration threshold output wrong");

    a_decel_thresh: assert property ( // see R6
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_ACC_DEC && !accelerating && decelerating
            && operationFreq + chkHalf <= detectionFrequencySetting
            && operationFreq + chkHalf >= operationFreq)
            |=> !relayOne
    ) else $error("deceleration threshold output set too early");

    a_decel_above: assert property ( // see R6
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_ACC_DEC && !accelerating && decelerating
            && operationFreq > detectionFrequencySetting)
            |=> relayOne
    ) else $error("deceleration threshold output missing");

    a_steady_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_ACC_DEC && !accelerating && !decelerating)
            |=> $stable(relayOne)
    ) else $error("threshold output changed in steady running");

    a_motor_ovl: assert property ( // see R7
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_MOTOR_OVL && motorOverload) |=> relayOne
    ) else $error("motor overload not shown");

    a_inv_ovl: assert property ( // see R8
        @(posedge clock) disable iff (!rst_n)
        (relayTwoSelect == DSO_SEL_INV_OVL)
            |=> (relayTwo == $past(inverterOverloadFault))
    ) else $error("inverter overload fault not followed");

    a_underload: assert property ( // see R9
        @(posedge clock) disable iff (!rst_n)
        (digitalOutputSelect == DSO_SEL_UNDERLOAD)
            |=> (openCollectorOutput == $past(underloadWarning))
    ) else $error("underload warning not followed");

    a_fan_warn: assert property ( // see R10
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_FAN_WARN && !fanWarning) |=> !relayOne
    ) else $error("fan warning shown while inactive");

    a_stall_ind: assert property ( // see R11
        @(posedge clock) disable iff (!rst_n)
        (relayTwoSelect == DSO_SEL_STALL) |=> (relayTwo == $past(motorStall))
    ) else $error("stall indication not followed");

    a_over_volt: assert property ( // see R12
        @(posedge clock) disable iff (!rst_n)
        (digitalOutputSelect == DSO_SEL_OVER_VOLT)
            |=> (openCollectorOutput == overVoltage)
    ) else $error("over-voltage selection disagrees with indication");

    a_ov_level: assert property ( // see R13
        @(posedge clock) disable iff (!rst_n)
        1'b1 |=> (overVoltage == ($past(dcLinkVoltage) > $past(overVoltageLevel)))
    ) else $error("over-voltage indication wrong");

    a_chan_split: assert property ( // see R14
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_NONE && relayTwoSelect == DSO_SEL_MOTOR_OVL
            && motorOverload) |=> (relayTwo && !relayOne)
    ) else $error("channels not independent");

    a_own_select: assert property ( // see R15
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_STALL && relayTwoSelect == DSO_SEL_NONE
            && motorStall) |=> (relayOne && !relayTwo)
    ) else $error("relay one ignores its selection");

    a_none_two: assert property ( // see R1
        @(posedge clock) disable iff (!rst_n)
        (relayTwoSelect == DSO_SEL_NONE) [*2] |-> !relayTwo
    ) else $error("relay two active with selection none");

    a_none_oc: assert property ( // see R1
        @(posedge clock) disable iff (!rst_n)
        (digitalOutputSelect == DSO_SEL_NONE) [*2] |-> !openCollectorOutput
    ) else $error("open collector active with selection none");

    a_refused_off: assert property (
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect > DSO_SEL_OVER_VOLT) |=> !relayOne
    ) else $error("relay one active with an unused selection");

    a_decel_exact: assert property ( // see R6
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_ACC_DEC && !accelerating && decelerating)
            |=> (relayOne == $past(chkDecel))
    ) else $error("deceleration threshold output wrong");

    a_motor_off: assert property ( // see R7
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_MOTOR_OVL && !motorOverload) |=> !relayOne
    ) else $error("motor overload shown while inactive");

    a_fan_on: assert property ( // see R10
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_FAN_WARN && fanWarning) |=> relayOne
    ) else $error("fan warning not shown");

    a_target_one: assert property ( // see R3
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_TARGET_REACH)
            |=> (relayOne == ($past(chkRef) && $past(chkTarget)))
    ) else $error("relay one target reach output wrong");

    a_op_one: assert property ( // see R4
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_OP_MATCH) |=> (relayOne == $past(chkOp))
    ) else $error("relay one operation match output wrong");

    a_inv_one: assert property ( // see R8
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_INV_OVL)
            |=> (relayOne == $past(inverterOverloadFault))
    ) else $error("relay one inverter overload not followed");

    a_under_one: assert property ( // see R9
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_UNDERLOAD)
            |=> (relayOne == $past(underloadWarning))
    ) else $error("relay one underload warning not followed");

    a_stall_one: assert property ( // see R11
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_STALL) |=> (relayOne == $past(motorStall))
    ) else $error("relay one stall indication not followed");

    a_ov_one: assert property ( // see R12
        @(posedge clock) disable iff (!rst_n)
        (relayOneSelect == DSO_SEL_OVER_VOLT) |=> (relayOne == overVoltage)
    ) else $error("relay one disagrees with over-voltage indication");

    a_ref_oc: assert property ( // see R2
        @(posedge clock) disable iff (!rst_n)
        (digitalOutputSelect == DSO_SEL_REF_REACH)
            |=> (openCollectorOutput == $past(chkRef))
    ) else $error("open collector reference reach output wrong");

    a_reset_clear: assert property ( // see R16
        @(posedge clock)
        !rst_n |=> (!relayOne && !relayTwo && !openCollectorOutput && !overVoltage)
    ) else $error("outputs not cleared by reset");

endmodule : dso_status_select

// >>> sim/dso_relay_model.sv
// relay coil driver model: the contact follows the coil drive one clock later
`timescale 1ns/1ps
module dso_relay_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // coil drive from the selector
    input wire logic coilDrive,
    // contact state seen by the load
    output logic contactClosed
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            contactClosed <= 1'h0;
        end else begin
            contactClosed <= coilDrive;
        end
    end
endmodule : dso_relay_model

// >>> sim/tb_top.sv
// self-checking bench for the drive status output selector
`timescale 1ns/1ps
module tb_top;
    import dso_pkg::*;
    typedef struct packed {
        logic [4:0] sel;
        logic [15:0] rf, of, opf, det, bnd;
        logic acc, dec;
        logic [4:0] flt;
        logic [11:0] v, lvl;
        logic exp;
    } dso_row_t;
    logic clock, rst_n, accelerating, decelerating;
    logic [4:0] relayOneSelect, relayTwoSelect, digitalOutputSelect, flt;
    logic [15:0] detectionFrequencySetting, detectionBandSetting;
    logic [15:0] referenceFreq, outputFreq, operationFreq;
    logic [11:0] dcLinkVoltage, overVoltageLevel;
    logic relayOne, relayTwo, openCollectorOutput, overVoltage, contactClosed, prev;
    int n_fail = 0;
    int n_compared = 0;
    // rows: sel, ref, out, op, detect, band, acc, dec, faults, volt, level, expected
    dso_row_t rows [21] = '{
        '{DSO_SEL_NONE, 16'h14, 16'h14, 16'h14, 16'h14, 16'hA, 1, 0, 5'h1F, 12'h65, 12'h64, 0},
        '{DSO_SEL_REF_REACH, 16'h14, 16'h18, 0, 16'h1E, 16'hA, 0, 0, 0, 0, 12'h64, 1},
        '{DSO_SEL_REF_REACH, 16'h14, 16'h19, 0, 16'h1E, 16'hA, 0, 0, 0, 0, 12'h64, 0},
        '{DSO_SEL_REF_REACH, 16'h14, 16'h19, 0, 16'h1E, 16'hB, 0, 0, 0, 0, 12'h64, 0},
        '{DSO_SEL_TARGET_REACH, 16'h1E, 16'h1A, 0, 16'h1E, 16'hA, 0, 0, 0, 0, 12'h64, 1},
        '{DSO_SEL_TARGET_REACH, 16'h14, 16'h14, 0, 16'h1E, 16'hA, 0, 0, 0, 0, 12'h64, 0},
        '{DSO_SEL_OP_MATCH, 0, 16'h1E, 16'h22, 16'h1E, 16'hA, 0, 0, 0, 0, 12'h64, 1},
        '{DSO_SEL_OP_MATCH, 0, 16'h1E, 16'h23, 16'h1E, 16'hA, 0, 0, 0, 0, 12'h64, 0},
        '{DSO_SEL_ACC_DEC, 0, 0, 16'h1E, 16'h1E, 16'hA, 1, 0, 0, 0, 12'h64, 1},
        '{DSO_SEL_ACC_DEC, 0, 0, 16'h1D, 16'h1E, 16'hA, 1, 0, 0, 0, 12'h64, 0},
        '{DSO_SEL_ACC_DEC, 0, 0, 16'h1A, 16'h1E, 16'hA, 0, 1, 0, 0, 12'h64, 1},
        '{DSO_SEL_ACC_DEC, 0, 0, 16'h19, 16'h1E, 16'hA, 0, 1, 0, 0, 12'h64, 0},
        '{DSO_SEL_MOTOR_OVL, 0, 0, 0, 16'h1E, 16'hA, 0, 0, 5'h10, 0, 12'h64, 1},
        '{DSO_SEL_MOTOR_OVL, 0, 0, 0, 16'h1E, 16'hA, 0, 0, 5'h0F, 0, 12'h64, 0},
        '{DSO_SEL_INV_OVL, 0, 0, 0, 16'h1E, 16'hA, 0, 0, 5'h08, 0, 12'h64, 1},
        '{DSO_SEL_UNDERLOAD, 0, 0, 0, 16'h1E, 16'hA, 0, 0, 5'h04, 0, 12'h64, 1},
        '{DSO_SEL_FAN_WARN, 0, 0, 0, 16'h1E, 16'hA, 0, 0, 5'h02, 0, 12'h64, 1},
        '{DSO_SEL_STALL, 0, 0, 0, 16'h1E, 16'hA, 0, 0, 5'h01, 0, 12'h64, 1},
        '{DSO_SEL_OVER_VOLT, 0, 0, 0, 16'h1E, 16'hA, 0, 0, 0, 12'h65, 12'h64, 1},
        '{DSO_SEL_OVER_VOLT, 0, 0, 0, 16'h1E, 16'hA, 0, 0, 0, 12'h64, 12'h64, 0},
        '{5'h0B, 16'h14, 16'h14, 16'h14, 16'h14, 16'hA, 1, 0, 5'h1F, 12'h65, 12'h64, 0}
    };

    dso_status_select dut_u (.clock(clock), .rst_n(rst_n),
        .relayOneSelect(relayOneSelect), .relayTwoSelect(relayTwoSelect),
        .digitalOutputSelect(digitalOutputSelect),
        .detectionFrequencySetting(detectionFrequencySetting),
        .detectionBandSetting(detectionBandSetting), .referenceFreq(referenceFreq),
        .outputFreq(outputFreq), .operationFreq(operationFreq),
        .accelerating(accelerating), .decelerating(decelerating),
        .motorOverload(flt[4]), .inverterOverloadFault(flt[3]),
        .underloadWarning(flt[2]), .fanWarning(flt[1]), .motorStall(flt[0]),
        .dcLinkVoltage(dcLinkVoltage), .overVoltageLevel(overVoltageLevel),
        .relayOne(relayOne), .relayTwo(relayTwo),
        .openCollectorOutput(openCollectorOutput), .overVoltage(overVoltage));
    dso_relay_model relay_u (.clock(clock), .rst_n(rst_n), .coilDrive(relayOne),
        .contactClosed(contactClosed));

    task automatic chk(input string what, input logic expv, input logic got);
        n_compared++;
        if (got !== expv) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", what, expv, got);
        end
    endtask : chk

    task automatic apply(input dso_row_t r);
        relayOneSelect = r.sel;
        digitalOutputSelect = r.sel;
        relayTwoSelect = DSO_SEL_STALL;
        referenceFreq = r.rf;
        outputFreq = r.of;
        operationFreq = r.opf;
        detectionFrequencySetting = r.det;
        detectionBandSetting = r.bnd;
        accelerating = r.acc;
        decelerating = r.dec;
        flt = r.flt;
        dcLinkVoltage = r.v;
        overVoltageLevel = r.lvl;
    endtask : apply

    task automatic give_verdict;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end

    initial begin
        repeat (2000) @(posedge clock);
        n_fail++;
        give_verdict();
    end

    initial begin
        rst_n = 1'h0;
        apply(rows[0]);
        prev = 1'h0;
        repeat (10) @(negedge clock);
        rst_n = 1'h1;
        foreach (rows[i]) begin
            @(negedge clock);
            apply(rows[i]);
            #10;
            chk("relayOne before edge", prev, relayOne);
            @(negedge clock);
            chk("relayOne", rows[i].exp, relayOne);
            chk("openCollectorOutput", rows[i].exp, openCollectorOutput);
            chk("relayTwo", rows[i].flt[0], relayTwo);
            chk("overVoltage", rows[i].v > rows[i].lvl, overVoltage);
            chk("contactClosed", prev, contactClosed);
            prev = rows[i].exp;
        end
        // code 4 with no direction keeps its last value, then deceleration clears it
        apply(rows[8]);
        @(negedge clock);
        accelerating = 1'h0;
        operationFreq = 16'h0;
        @(negedge clock);
        chk("relayOne hold", 1'h1, relayOne);
        decelerating = 1'h1;
        @(negedge clock);
        chk("relayOne decel", 1'h0, relayOne);
        // relay two on codes of its own while relay one is set apart
        apply(rows[4]);
        relayOneSelect = DSO_SEL_NONE;
        relayTwoSelect = DSO_SEL_TARGET_REACH;
        @(negedge clock);
        chk("relayTwo target", 1'h1, relayTwo);
        chk("relayOne none", 1'h0, relayOne);
        relayOneSelect = DSO_SEL_STALL;
        relayTwoSelect = DSO_SEL_NONE;
        flt = 5'h19;
        repeat (2) @(negedge clock);
        chk("relayOne own", 1'h1, relayOne);
        chk("relayTwo none", 1'h0, relayTwo);
        relayOneSelect = DSO_SEL_NONE;
        relayTwoSelect = DSO_SEL_MOTOR_OVL;
        @(negedge clock);
        chk("relayTwo split", 1'h1, relayTwo);
        chk("relayOne split", 1'h0, relayOne);
        relayTwoSelect = DSO_SEL_INV_OVL;
        flt = 5'h08;
        @(negedge clock);
        chk("relayTwo inverter", 1'h1, relayTwo);
        // reset in mid-run with motor overload and over-voltage active
        apply(rows[12]);
        dcLinkVoltage = 12'hFFF;
        @(negedge clock);
        chk("relayOne set", 1'h1, relayOne);
        rst_n = 1'h0;
        @(negedge clock);
        chk("relayOne reset", 1'h0, relayOne);
        chk("openCollectorOutput reset", 1'h0, openCollectorOutput);
        chk("overVoltage reset", 1'h0, overVoltage);
        rst_n = 1'h1;
        @(negedge clock);
        chk("relayOne after reset", 1'h1, relayOne);
        give_verdict();
    end
endmodule : tb_top
